// ===== tvi_cfg.svh
// Constants for the two-level vectored interrupt unit.
`ifndef TVI_CFG_SVH
`define TVI_CFG_SVH

`define TVI_ADDR_ENABLE_MAIN 8'ha8
`define TVI_ADDR_PRIORITY_MAIN 8'hb8
`define TVI_ADDR_REQUEST_FLAGS 8'hc0
`define TVI_ADDR_SENSITIVITY 8'he1
`define TVI_ADDR_PORT_ENABLE 8'he8
`define TVI_ADDR_POLARITY 8'he9
`define TVI_ADDR_ENABLE_AUX 8'hf1
`define TVI_ADDR_PORT_PRIORITY 8'hf8
`define TVI_ADDR_PRIORITY_AUX 8'hf9

`define TVI_GLOBAL_GATE_BIT 7
`define TVI_REG_RESET 8'h00
`define TVI_MASK_FULL 8'hff
`define TVI_MASK_PRIORITY_MAIN 8'h7f
`define TVI_MASK_AUX 8'h1f

`define TVI_SRC_COUNT 20
`define TVI_PORT_LINES 8
`define TVI_VEC_LOW_BITS 3'h3
`define TVI_VEC_HIGH_BYTE 8'h00

`endif

// ===== tvi_pkg.sv
// Types shared by the two-level vectored interrupt unit.
package tvi_pkg;

  typedef logic [4:0] tvi_vecnum_t;

  typedef logic [19:0] tvi_srcvec_t;

  typedef enum logic
  {
    TVI_LEVEL_LOW = 1'b0,
    TVI_LEVEL_HIGH = 1'b1
  } tvi_level_t;

endpackage

// ===== tvi_interrupt_unit.sv
// Two-level nested vectored interrupt unit with eight port-line interrupt inputs.
// Function
// - Twenty sources request service: ten external, three timers, serial, UART, modem, LOW_VOLTAGE_DETECTOR, clock.
// - Each source branches to its own fixed vector, 0003 hex up to 009B hex.
// - Same-level requests resolve in fixed table order, external 0 first, clock last.
// - Each source has one of two levels; high wins when both request.
// - A running low-level handler is preempted only by a high-level request.
// - A running high-level handler is never preempted.
// - Global gate bit 7 of main enable blocks every source when zero.
// - Clearing the global gate blocks servicing and idle exit, not detection or pending flags.
// - Port lines 0 to 7 act as external inputs 2 to 9.
// - Polarity bit 1 selects high or rising, 0 selects low or falling.
// - Sensitivity bit 1 selects edge detection, 0 selects level detection.
// - A level request counts only when held active for one machine cycle.
// - A recognised port request is not serviced before the next machine cycle.
// - Enabled port detections set sticky flags that only software writes clear.
// - An enabled port input request can wake the device from power-down.
// - Main enable bits 6 to 0 enable timer 2 down to external 0.
// - Port enable bits 7 to 0 enable external inputs 9 to 2.
// - Aux enable bits 4 to 0 enable clock, LOW_VOLTAGE_DETECTOR, UART tx, modem tx, rx.
// - Main priority bits 6 to 0 set levels; bit 7 reserved.
// - Port priority bits 7 to 0 set levels of external inputs 9 to 2.
// - Aux priority bits 4 to 0 set levels; bits 7 to 5 reserved.
// - The request flag register holds one readable sticky flag per port input.
// - An enabled request during idle, with the global gate open, raises idleExit to end idle.
`include "tvi_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module tvi_interrupt_unit
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic machineCycle,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic sfrSel,
  output logic [7:0] sfrRdData,
  input wire logic [7:0] portPin,
  input wire logic [1:0] extReq,
  input wire logic [2:0] timerReq,
  input wire logic twowireReq,
  input wire logic uartTxReq,
  input wire logic uartRxReq,
  input wire logic modemTxReq,
  input wire logic modemRxReq,
  input wire logic lowVoltReq,
  input wire logic clockReq,
  output logic irqReq,
  output logic [15:0] irqVector,
  input wire logic vecTaken,
  input wire logic retDone,
  output logic [19:0] srcAck,
  output logic [1:0] inService,
  input wire logic idleActive,
  output logic idleExit,
  output logic wakeReq
);

  logic [7:0] enableMain_r;
  logic [7:0] priorityMain_r;
  logic [7:0] requestFlags_r;
  logic [7:0] sensitivity_r;
  logic [7:0] portEnable_r;
  logic [7:0] polarity_r;
  logic [7:0] enableAux_r;
  logic [7:0] portPriority_r;
  logic [7:0] priorityAux_r;
  logic [7:0] requestFlags_nxt;
  logic [7:0] sfrRdData_r;
  logic [7:0] readMux;
  logic [7:0] syncA_r;
  logic [7:0] syncB_r;
  logic [7:0] syncC_r;
  logic [7:0] stable_r;
  logic [7:0] stablePrev_r;
  logic [7:0] levelSeen_r;
  logic [7:0] portActive;
  logic [7:0] portDetect;
  tvi_pkg::tvi_srcvec_t srcReq;
  tvi_pkg::tvi_srcvec_t srcEnable;
  tvi_pkg::tvi_srcvec_t srcLevel;
  tvi_pkg::tvi_srcvec_t pendSnap_r;
  tvi_pkg::tvi_srcvec_t srcAck_r;
  logic globalGate;
  logic highFound;
  logic lowFound;
  tvi_pkg::tvi_vecnum_t highVec;
  tvi_pkg::tvi_vecnum_t lowVec;
  logic found;
  tvi_pkg::tvi_vecnum_t winVec;
  tvi_pkg::tvi_level_t winLevel;
  logic irqReq_r;
  tvi_pkg::tvi_vecnum_t irqVec_r;
  tvi_pkg::tvi_level_t irqLevel_r;
  logic inSvcHigh_r;
  logic inSvcLow_r;
  logic idleExit_r;
  logic take;

  // Vector numbers listed in the fixed resolution order, highest first.
  localparam tvi_pkg::tvi_vecnum_t resOrder [`TVI_SRC_COUNT] = '{
    5'h00, 5'h05, 5'h0a, 5'h11, 5'h01, 5'h06, 5'h0b, 5'h10, 5'h02, 5'h07,
    5'h0c, 5'h0f, 5'h03, 5'h08, 5'h0d, 5'h12, 5'h04, 5'h09, 5'h0e, 5'h13};

  // Returns the earliest candidate in resolution order; bit 5 flags that one exists.
  function automatic logic [5:0] pickFirst(input tvi_pkg::tvi_srcvec_t cand);
    logic [5:0] r;
    tvi_pkg::tvi_vecnum_t v;
    r = 6'h00;
    v = 5'h00;
    for (int p = `TVI_SRC_COUNT - 1; p >= 0; p--)
    begin
      v = resOrder[p];
      if (cand[v])
      begin
        r = {1'b1, v};
      end
    end
    return r;
  endfunction

  assign globalGate = enableMain_r[`TVI_GLOBAL_GATE_BIT];

  // Source vectors are indexed by vector number.
  assign srcReq = {clockReq, lowVoltReq, modemRxReq, modemTxReq, uartTxReq,
                   requestFlags_r, timerReq[2], twowireReq, uartRxReq,
                   timerReq[1], extReq[1], timerReq[0], extReq[0]};
  assign srcEnable = {enableAux_r[4], enableAux_r[3], enableAux_r[0], enableAux_r[1],
                      enableAux_r[2], portEnable_r, enableMain_r[6:0]};
  assign srcLevel = {priorityAux_r[4], priorityAux_r[3], priorityAux_r[0],
                     priorityAux_r[1], priorityAux_r[2], portPriority_r,
                     priorityMain_r[6:0]};

  // Register decode and read path.
  always_comb
  begin
    sfrSel = 1'b1;
    readMux = `TVI_REG_RESET;
    unique case (sfrAddr)
      `TVI_ADDR_ENABLE_MAIN: readMux = enableMain_r;
      `TVI_ADDR_PRIORITY_MAIN: readMux = priorityMain_r & `TVI_MASK_PRIORITY_MAIN;
      `TVI_ADDR_REQUEST_FLAGS: readMux = requestFlags_r;
      `TVI_ADDR_SENSITIVITY: readMux = sensitivity_r;
      `TVI_ADDR_PORT_ENABLE: readMux = portEnable_r;
      `TVI_ADDR_POLARITY: readMux = polarity_r;
      `TVI_ADDR_ENABLE_AUX: readMux = enableAux_r & `TVI_MASK_AUX;
      `TVI_ADDR_PORT_PRIORITY: readMux = portPriority_r;
      `TVI_ADDR_PRIORITY_AUX: readMux = priorityAux_r & `TVI_MASK_AUX;
      default: sfrSel = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sfrRdData_r <= `TVI_REG_RESET;
    end
    else if (clkEn && sfrRd)
    begin
      sfrRdData_r <= readMux;
    end
  end

  // Configuration registers; reserved bits are never stored.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      enableMain_r <= `TVI_REG_RESET;
      priorityMain_r <= `TVI_REG_RESET;
      sensitivity_r <= `TVI_REG_RESET;
      portEnable_r <= `TVI_REG_RESET;
      polarity_r <= `TVI_REG_RESET;
      enableAux_r <= `TVI_REG_RESET;
      portPriority_r <= `TVI_REG_RESET;
      priorityAux_r <= `TVI_REG_RESET;
    end
    else if (clkEn && sfrWr)
    begin
      unique case (sfrAddr)
        `TVI_ADDR_ENABLE_MAIN: enableMain_r <= sfrWrData;
        `TVI_ADDR_PRIORITY_MAIN: priorityMain_r <= sfrWrData & `TVI_MASK_PRIORITY_MAIN;
        `TVI_ADDR_SENSITIVITY: sensitivity_r <= sfrWrData;
        `TVI_ADDR_PORT_ENABLE: portEnable_r <= sfrWrData;
        `TVI_ADDR_POLARITY: polarity_r <= sfrWrData;
        `TVI_ADDR_ENABLE_AUX: enableAux_r <= sfrWrData & `TVI_MASK_AUX;
        `TVI_ADDR_PORT_PRIORITY: portPriority_r <= sfrWrData;
        `TVI_ADDR_PRIORITY_AUX: priorityAux_r <= sfrWrData & `TVI_MASK_AUX;
        default: ;
      endcase
    end
  end

  // Port pins pass three flip-flops; a value counts once the last two agree.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      syncA_r <= `TVI_REG_RESET;
      syncB_r <= `TVI_REG_RESET;
      syncC_r <= `TVI_REG_RESET;
      stable_r <= `TVI_REG_RESET;
      stablePrev_r <= `TVI_REG_RESET;
    end
    else if (clkEn)
    begin
      syncA_r <= portPin;
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      stable_r <= (syncB_r & ~(syncB_r ^ syncC_r)) | (stable_r & (syncB_r ^ syncC_r));
      stablePrev_r <= stable_r;
    end
  end

  // Per-line detection: polarity, edge or level, and the one-cycle hold.
  genvar g;
  generate
    for (g = 0; g < `TVI_PORT_LINES; g++)
    begin : gLine
      assign portActive[g] = polarity_r[g] ? stable_r[g] : ~stable_r[g];
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          levelSeen_r[g] <= 1'b0;
        end
        else if (clkEn && machineCycle)
        begin
          levelSeen_r[g] <= portActive[g];
        end
      end
      assign portDetect[g] = sensitivity_r[g] ?
        (portActive[g] && (stablePrev_r[g] != stable_r[g])) :
        (portActive[g] && levelSeen_r[g] && machineCycle);
    end
  endgenerate

  // Sticky flags: detection sets, software writes clear, set wins the race.
  always_comb
  begin
    requestFlags_nxt = requestFlags_r;
    if (sfrWr && sfrAddr == `TVI_ADDR_REQUEST_FLAGS)
    begin
      requestFlags_nxt = sfrWrData;
    end
    requestFlags_nxt = requestFlags_nxt | (portDetect & portEnable_r);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      requestFlags_r <= `TVI_REG_RESET;
    end
    else if (clkEn)
    begin
      requestFlags_r <= requestFlags_nxt;
    end
  end

  // Pending set is sampled once per machine cycle, so a fresh flag waits one.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pendSnap_r <= '0;
    end
    else if (clkEn && machineCycle)
    begin
      pendSnap_r <= srcReq & srcEnable;
    end
  end

  // Arbitration over the snapshot with nesting limits.
  assign {highFound, highVec} = pickFirst(pendSnap_r & srcLevel);
  assign {lowFound, lowVec} = pickFirst(pendSnap_r & ~srcLevel);

  always_comb
  begin
    found = 1'b0;
    winVec = highVec;
    winLevel = tvi_pkg::TVI_LEVEL_HIGH;
    if (!inSvcHigh_r)
    begin
      if (highFound)
      begin
        found = 1'b1;
      end
      else if (lowFound && !inSvcLow_r)
      begin
        found = 1'b1;
        winVec = lowVec;
        winLevel = tvi_pkg::TVI_LEVEL_LOW;
      end
    end
  end

  assign take = vecTaken && irqReq_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irqReq_r <= 1'b0;
      irqVec_r <= 5'h00;
      irqLevel_r <= tvi_pkg::TVI_LEVEL_LOW;
    end
    else if (clkEn)
    begin
      irqReq_r <= found && globalGate && !vecTaken;
      if (!irqReq_r || !vecTaken)
      begin
        irqVec_r <= winVec;
        irqLevel_r <= winLevel;
      end
    end
  end

  // In-service levels: the core's vector fetch pushes, its return pops.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      inSvcHigh_r <= 1'b0;
      inSvcLow_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (take)
      begin
        if (irqLevel_r == tvi_pkg::TVI_LEVEL_HIGH)
        begin
          inSvcHigh_r <= 1'b1;
        end
        else
        begin
          inSvcLow_r <= 1'b1;
        end
      end
      else if (retDone)
      begin
        if (inSvcHigh_r)
        begin
          inSvcHigh_r <= 1'b0;
        end
        else
        begin
          inSvcLow_r <= 1'b0;
        end
      end
    end
  end

  // Acknowledge pulse to the source that was vectored.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      srcAck_r <= '0;
    end
    else if (clkEn)
    begin
      srcAck_r <= take ? (20'h00001 << irqVec_r) : 20'h00000;
    end
  end

  // Idle ends when any enabled request is present while the gate is open.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      idleExit_r <= 1'b0;
    end
    else if (clkEn)
    begin
      idleExit_r <= idleActive && globalGate && (|(srcReq & srcEnable));
    end
  end

  assign sfrRdData = sfrRdData_r;
  assign irqReq = irqReq_r;
  assign irqVector = {`TVI_VEC_HIGH_BYTE, irqVec_r, `TVI_VEC_LOW_BITS};
  assign srcAck = srcAck_r;
  assign inService = {inSvcHigh_r, inSvcLow_r};
  assign idleExit = idleExit_r;
  // Wake works with the clock stopped, so it looks at raw pins as well as flags.
  assign wakeReq = |(portEnable_r & ((portPin ~^ polarity_r) | requestFlags_r));

endmodule

`default_nettype wire

// ===== tvi_chk.sv
// Port-level checker for the two-level vectored interrupt unit.
`timescale 1ns/100ps
`default_nettype none
module tvi_chk
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic sfrSel,
  input wire logic [7:0] sfrRdData,
  input wire logic irqReq,
  input wire logic [15:0] irqVector,
  input wire logic vecTaken,
  input wire logic [19:0] srcAck,
  input wire logic [1:0] inService,
  input wire logic idleActive,
  input wire logic idleExit
);
  logic gate_r;
  logic gateOld_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Mirrors the global gate bit and its value one cycle earlier.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gate_r <= 1'b0;
      gateOld_r <= 1'b0;
    end
    else if (clkEn)
    begin
      if (sfrWr && sfrAddr == 8'ha8)
      begin
        gate_r <= sfrWrData[7];
      end
      gateOld_r <= gate_r;
    end
  end
  property p_vecForm;
    irqReq |-> irqVector[2:0] == 3'h3 && irqVector <= 16'h009b;
  endproperty
  a_vecForm: assert property (p_vecForm) else $error("Offered vector malformed");
  property p_ackBit;
    irqReq && vecTaken && clkEn |=> srcAck == (20'h1 << $past(irqVector[7:3]));
  endproperty
  a_ackBit: assert property (p_ackBit) else $error("Acknowledge bit wrong");
  property p_ackPulse;
    |srcAck |=> srcAck == 20'h0;
  endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("Acknowledge longer than one cycle");
  property p_highHold;
    inService[1] |-> !irqReq;
  endproperty
  a_highHold: assert property (p_highHold) else $error("Offer during high handler");
  property p_lowNest;
    inService == 2'b01 && irqReq && vecTaken && clkEn |=> inService[1];
  endproperty
  a_lowNest: assert property (p_lowNest) else $error("Preempting offer not high");
  property p_gate;
    !gate_r && !gateOld_r |-> !irqReq;
  endproperty
  a_gate: assert property (p_gate) else $error("Offer with global gate off");
  property p_sel;
    sfrSel == (sfrAddr inside {8'ha8, 8'hb8, 8'hc0, 8'he1, 8'he8, 8'he9, 8'hf1, 8'hf8, 8'hf9});
  endproperty
  a_sel: assert property (p_sel) else $error("Register select wrong");
  property p_unmap;
    sfrRd && clkEn && !sfrSel |=> sfrRdData == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("Unmapped read not zero");
  property p_idle;
    idleExit |-> $past(idleActive);
  endproperty
  a_idle: assert property (p_idle) else $error("Idle exit without idle");
  c_nest: cover property (inService == 2'b11);
  c_idle: cover property (idleExit);
  c_unmap: cover property (sfrRd && !sfrSel);
endmodule
bind tvi_interrupt_unit tvi_chk tvi_chk_inst
(
  .ref_clk, .rst, .clkEn, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrSel, .sfrRdData,
  .irqReq, .irqVector, .vecTaken, .srcAck, .inService, .idleActive, .idleExit
);
`default_nettype wire

// ===== tvi_core_model.sv
// Behavioural core that paces machine cycles, takes vectors and returns.
`timescale 1ns/100ps
`default_nettype none
module tvi_core_model
#(
  parameter int TAKE_DLY = 2
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic irqReq,
  input wire logic [15:0] irqVector,
  input wire logic takeEn,
  input wire logic retCmd,
  output logic vecTaken,
  output logic retDone,
  output logic machineCycle,
  output logic [15:0] lastVec
);
  logic [2:0] phase_r;
  int waitCnt;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_r <= 3'h0;
      machineCycle <= 1'b0;
      retDone <= 1'b0;
      vecTaken <= 1'b0;
      lastVec <= 16'h0000;
      waitCnt <= 0;
    end
    else
    begin
      phase_r <= (phase_r == 3'h5) ? 3'h0 : phase_r + 3'h1;
      machineCycle <= phase_r == 3'h5;
      retDone <= retCmd;
      vecTaken <= 1'b0;
      waitCnt <= 0;
      if (irqReq && takeEn && !vecTaken)
      begin
        waitCnt <= waitCnt + 1;
        if (waitCnt >= TAKE_DLY)
        begin
          vecTaken <= 1'b1;
          lastVec <= irqVector;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tvi_interrupt_unit_test.sv
// Self-checking bench for the two-level vectored interrupt unit.
`timescale 1ns/100ps
`default_nettype none
module tvi_interrupt_unit_test;
  logic ref_clk, rst, clkEn, sfrWr, sfrRd, takeEn, retCmd, idleActive;
  logic sfrSel, irqReq, vecTaken, retDone, machineCycle, idleExit, wakeReq;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, portPin;
  logic [19:0] reqAll, srcAck;
  logic [15:0] irqVector, lastVec;
  logic [1:0] inService;
  int bad_count, n_checks;
  logic [7:0] regA [9] = '{8'ha8, 8'hb8, 8'hc0, 8'he1, 8'he8, 8'he9, 8'hf1, 8'hf8, 8'hf9};
  logic [7:0] regM [9] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h1f};
  logic [7:0] order [12] = '{8'h03, 8'h2b, 8'h8b, 8'h0b, 8'h33, 8'h83, 8'h13, 8'h7b, 8'h1b,
    8'h93, 8'h23, 8'h9b};
  tvi_interrupt_unit tvi_interrupt_unit_inst
  (
    .ref_clk, .rst, .clkEn, .machineCycle, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrSel,
    .sfrRdData, .portPin, .extReq({reqAll[2], reqAll[0]}),
    .timerReq({reqAll[6], reqAll[3], reqAll[1]}), .twowireReq(reqAll[5]),
    .uartTxReq(reqAll[15]), .uartRxReq(reqAll[4]), .modemTxReq(reqAll[16]),
    .modemRxReq(reqAll[17]), .lowVoltReq(reqAll[18]), .clockReq(reqAll[19]), .irqReq,
    .irqVector, .vecTaken, .retDone, .srcAck, .inService, .idleActive, .idleExit, .wakeReq
  );
  tvi_core_model tvi_core_model_inst
  (
    .ref_clk, .rst, .irqReq, .irqVector, .takeEn, .retCmd, .vecTaken, .retDone,
    .machineCycle, .lastVec
  );
  always #4 ref_clk = ~ref_clk;
  task automatic final_report;
    $display("Checks %0d, errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = 1'b1;
    cyc(1);
    sfrWr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfrAddr = a;
    sfrRd = 1'b1;
    cyc(1);
    sfrRd = 1'b0;
    chk({8'h00, sfrRdData}, {8'h00, e});
    cyc(1);
  endtask
  task automatic rt;
    retCmd = 1'b1;
    cyc(1);
    retCmd = 1'b0;
    cyc(1);
  endtask
  // Waits for a taken vector, clears the acknowledged request, then optionally returns.
  task automatic svc(input logic [7:0] v, input logic r);
    for (int i = 0; i < 200 && srcAck === 20'h0; i++) cyc(1);
    if (srcAck === 20'h0)
    begin
      bad_count++;
      final_report();
    end
    chk(lastVec, {8'h00, v});
    reqAll = reqAll & ~srcAck;
    if (r)
    begin
      cyc(12);
      rt();
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {sfrWr, sfrRd, takeEn, retCmd, idleActive} = 5'h00;
    clkEn = 1'b1;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    portPin = 8'h80;
    reqAll = 20'h00000;
    cyc(3);
    rst = 1'b0;
    for (int k = 0; k < 9; k++) rd(regA[k], 8'h00);
    chk({15'h0000, wakeReq}, 16'h0000);
    clkEn = 1'b0;
    wr(8'hf8, 8'h5a);
    clkEn = 1'b1;
    rd(8'hf8, 8'h00);
    rd(8'h87, 8'h00);
    chk({15'h0000, sfrSel}, 16'h0000);
    for (int k = 0; k < 9; k++) wr(regA[k], 8'hff);
    for (int k = 0; k < 9; k++) rd(regA[k], regM[k]);
    wr(8'he8, 8'h00);
    for (int k = 0; k < 9; k++) wr(regA[k], 8'h00);
    wr(8'h87, 8'h5a);
    rd(8'h87, 8'h00);
    wr(8'ha8, 8'hff);
    wr(8'hf1, 8'h1f);
    wr(8'hb8, 8'h08);
    reqAll = 20'hf807f;
    takeEn = 1'b1;
    svc(8'h1b, 1'b1);
    for (int k = 0; k < 12; k++) if (order[k] != 8'h1b) svc(order[k], 1'b1);
    wr(8'ha8, 8'h8f);
    reqAll[0] = 1'b1;
    svc(8'h03, 1'b0);
    reqAll[2] = 1'b1;
    cyc(24);
    chk(irqReq, 1'b0);
    reqAll[3] = 1'b1;
    svc(8'h1b, 1'b0);
    chk({14'h0000, inService}, 16'h0003);
    reqAll[1] = 1'b1;
    cyc(24);
    chk(irqReq, 1'b0);
    rt();
    cyc(12);
    chk(irqReq, 1'b0);
    rt();
    svc(8'h0b, 1'b1);
    svc(8'h13, 1'b1);
    takeEn = 1'b0;
    wr(8'ha8, 8'h01);
    reqAll[0] = 1'b1;
    idleActive = 1'b1;
    cyc(24);
    chk(irqReq, 1'b0);
    wr(8'ha8, 8'h81);
    cyc(12);
    chk(idleExit, 1'b1);
    chk(irqReq, 1'b1);
    idleActive = 1'b0;
    takeEn = 1'b1;
    svc(8'h03, 1'b1);
    wr(8'ha8, 8'h00);
    wr(8'he1, 8'h01);
    wr(8'he9, 8'h01);
    wr(8'he8, 8'h81);
    portPin[0] = 1'b1;
    cyc(12);
    portPin[0] = 1'b0;
    cyc(12);
    rd(8'hc0, 8'h01);
    chk(wakeReq, 1'b1);
    wr(8'ha8, 8'h80);
    svc(8'h3b, 1'b0);
    rd(8'hc0, 8'h01);
    wr(8'hc0, 8'h00);
    rt();
    portPin[7] = 1'b0;
    cyc(3);
    portPin[7] = 1'b1;
    cyc(24);
    rd(8'hc0, 8'h00);
    portPin[7] = 1'b0;
    svc(8'h73, 1'b0);
    portPin[7] = 1'b1;
    cyc(12);
    rd(8'hc0, 8'h80);
    wr(8'hc0, 8'h00);
    rd(8'hc0, 8'h00);
    chk({15'h0000, wakeReq}, 16'h0000);
    rt();
    final_report();
  end
endmodule
`default_nettype wire
